/* File: hdrm_ring_mgr.sv */
// descriptor ring manager: apb registers, ring walking, descriptor write-back, error counters
// What this block does
// - receive ring holds two to the size code entries; code zero is refused
// - with busy reporting enabled, each remote busy change issues primitive code 5
// - transmit ring holds two to the size code entries, one through 128
// - unacknowledged frames never exceed window; window decoded by extended control setting
// - xid and test descriptors behave like ring ones but never chain
// - status request writes seven link status words at status buffer base
// - error counters in memory are only ever incremented by the device
// - six error counters sit at init base plus 44 to 54, step 2
// - every ring entry spans four consecutive 16-bit words
// - owner bit cleared after fill only for good frames; host sets it back
// - a descriptor handed over is not touched again by its former owner
// - the secondary owner bit is ignored and kept as read
// - first buffer of a frame gets start flag, last gets end flag
// - ui and reject report flags mark buffers of those received frames
// - address match flag set for local address, cleared for remote address
// - poll/final bit copied only for ui, xid and test frames
// - buffer pointer words of a descriptor are never modified by the device
// - message length written as two's complement; non-final buffers report full length
// - extended control gives two-octet control fields and modulo 128 numbering
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "hdrm_regs.svh"
`default_nettype none

module hdrm_ring_mgr (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system memory word port
    output logic mem_req,
    output logic mem_we,
    output logic [23:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    // receive buffer completion from the protocol engine
    input wire logic rx_done,
    input wire logic rx_last,
    input wire logic rx_good,
    input wire hdrm_pkg::hdrm_kind_t rx_kind,
    input wire logic rx_pf,
    input wire logic rx_match,
    input wire logic [15:0] rx_count,
    output logic cmd_ready,
    // status report request
    input wire logic stat_req,
    input wire logic [111:0] stat_words,
    // error events, one pulse per counted event
    input wire logic [5:0] err_event,
    // transmit side
    input wire logic tx_sent,
    input wire logic tx_ack,
    input wire logic [6:0] tx_nr,
    output logic tx_window_open,
    output logic [6:0] tx_idx,
    output logic two_octet_ctrl,
    output logic [6:0] seq_mask,
    // remote busy primitive
    input wire logic remote_busy,
    output logic prim_valid,
    output logic [3:0] prim_code
);
    import hdrm_pkg::*;

    hdrm_state_t s_ff;
    hdrm_state_t nxt_s;

    // --------
    // helpers
    // --------

    // index mask of a ring of two to the code entries
    function automatic logic [6:0] ring_mask(input logic [2:0] code);
        ring_mask = 7'((8'h01 << code) - 8'h01);
    endfunction

    // byte address of entry idx, four 16-bit words per entry
    function automatic logic [23:0] entry_addr(input logic [23:0] base, input logic [6:0] idx);
        entry_addr = base + {14'h0000, idx, 3'h0};
    endfunction

    // window size from the code and the extended control setting
    function automatic logic [6:0] win_size(input logic [2:0] code, input logic ext);
        if (!ext) begin
            win_size = {4'h0, code}; // code zero gives zero: nothing may be sent
        end else if (code == 3'h7) begin
            win_size = `HDRM_WIN_MAX;
        end else begin
            win_size = 7'((8'h02 << code) - 8'h01);
        end
    endfunction

    // --------
    // next state
    // --------

    // one pass computes every next value of the state
    always_comb begin
        logic [6:0] outstanding;
        logic [6:0] nxt_idx;
        logic [23:0] rx_base;
        logic wr_now;
        nxt_s = s_ff;
        wr_now = psel && penable && pwrite && s_ff.pready;
        outstanding = 7'h00;
        nxt_idx = 7'h00;
        rx_base = {s_ff.rx_ptr[`HDRM_HI_MSB:0], s_ff.rx_lo};
        nxt_s.pready = 1'b0;
        nxt_s.pslverr = 1'b0;
        nxt_s.prim_valid = 1'b0;

        // apb access: answer after one wait cycle, a write lands on the edge that samples pready
        if (psel && penable) begin
            nxt_s.pready = !s_ff.pready;
            nxt_s.prdata = 32'h00000000;
            case (paddr)
                `HDRM_RX_RING_PTR: begin
                    if (wr_now) nxt_s.rx_ptr = pwdata[15:0] & `HDRM_RX_PTR_MASK;
                    nxt_s.prdata = {16'h0000, s_ff.rx_ptr};
                end
                `HDRM_RX_RING_LO: begin
                    if (wr_now) nxt_s.rx_lo = pwdata[15:0];
                    nxt_s.prdata = {16'h0000, s_ff.rx_lo};
                end
                `HDRM_TX_RING_PTR: begin
                    if (wr_now) nxt_s.tx_ptr = pwdata[15:0] & `HDRM_TX_PTR_MASK;
                    nxt_s.prdata = {16'h0000, s_ff.tx_ptr};
                end
                `HDRM_TX_RING_LO: begin
                    if (wr_now) nxt_s.tx_lo = pwdata[15:0];
                    nxt_s.prdata = {16'h0000, s_ff.tx_lo};
                end
                `HDRM_STAT_BUF_PTR: begin
                    if (wr_now) nxt_s.sb_hi = pwdata[7:0];
                    nxt_s.prdata = {24'h000000, s_ff.sb_hi};
                end
                `HDRM_STAT_BUF_LO: begin
                    if (wr_now) nxt_s.sb_lo = pwdata[15:0];
                    nxt_s.prdata = {16'h0000, s_ff.sb_lo};
                end
                `HDRM_INIT_BASE: begin
                    if (wr_now) nxt_s.init_base = pwdata[23:0];
                    nxt_s.prdata = {8'h00, s_ff.init_base};
                end
                `HDRM_XID_DESC: begin
                    if (wr_now) nxt_s.xid_desc = pwdata[23:0];
                    nxt_s.prdata = {8'h00, s_ff.xid_desc};
                end
                `HDRM_TEST_DESC: begin
                    if (wr_now) nxt_s.test_desc = pwdata[23:0];
                    nxt_s.prdata = {8'h00, s_ff.test_desc};
                end
                `HDRM_CTRL: begin
                    if (wr_now) nxt_s.ext_en = pwdata[0];
                    nxt_s.prdata = {31'h00000000, s_ff.ext_en};
                end
                `HDRM_STATUS: begin
                    // write one to clear; a set in the same cycle wins below
                    if (wr_now && pwdata[`HDRM_ST_NODESC_BIT]) nxt_s.rx_nodesc = 1'b0;
                    if (wr_now && pwdata[`HDRM_ST_CFGERR_BIT]) nxt_s.cfg_err = 1'b0;
                    nxt_s.prdata = {5'h00, s_ff.cfg_err, s_ff.rx_nodesc, s_ff.st != ST_IDLE,
                                    1'b0, s_ff.vs - s_ff.va, 1'b0, s_ff.tx_idx, 1'b0, s_ff.rx_idx};
                end
                default: begin
                    nxt_s.pslverr = !s_ff.pready;
                end
            endcase
            // read data holds once the answer cycle is over
            if (s_ff.pready) nxt_s.prdata = s_ff.prdata;
        end

        // remote busy change reported as a primitive when enabled
        nxt_s.rb_prev = remote_busy;
        if (s_ff.rx_ptr[`HDRM_RB_EN_BIT] && (remote_busy != s_ff.rb_prev)) begin
            nxt_s.prim_valid = 1'b1;
            nxt_s.prim_code = `HDRM_PRIM_REMOTE_BUSY;
        end

        // transmit ring walk and window accounting
        nxt_s.seq_mask = s_ff.ext_en ? 7'h7F : 7'h07;
        nxt_s.two_octet_ctrl = s_ff.ext_en;
        if (tx_sent) begin
            nxt_s.tx_idx = (s_ff.tx_idx + 7'h01) & ring_mask(s_ff.tx_ptr[`HDRM_SIZE_MSB:`HDRM_SIZE_LSB]);
            nxt_s.vs = (s_ff.vs + 7'h01) & nxt_s.seq_mask;
        end
        if (tx_ack) nxt_s.va = tx_nr & nxt_s.seq_mask;
        outstanding = (nxt_s.vs - nxt_s.va) & nxt_s.seq_mask;
        nxt_s.tx_window_open = outstanding < win_size(s_ff.tx_ptr[`HDRM_WIN_MSB:`HDRM_WIN_LSB], s_ff.ext_en);

        // memory sequencer
        case (s_ff.st)
            ST_IDLE: begin
                if (rx_done) begin
                    nxt_s.rx_last = rx_last;
                    nxt_s.rx_good = rx_good;
                    nxt_s.rx_kind = rx_kind;
                    nxt_s.rx_pf = rx_pf;
                    nxt_s.rx_match = rx_match;
                    nxt_s.rx_count = rx_count;
                    if (rx_kind == KIND_XID || rx_kind == KIND_TEST) begin
                        nxt_s.desc_ring = 1'b0;
                        nxt_s.desc_addr = (rx_kind == KIND_XID) ? s_ff.xid_desc : s_ff.test_desc;
                        nxt_s.st = ST_RX_RD0;
                    end else if (s_ff.rx_ptr[`HDRM_SIZE_MSB:`HDRM_SIZE_LSB] == 3'h0) begin
                        nxt_s.cfg_err = 1'b1;
                    end else begin
                        nxt_s.desc_ring = 1'b1;
                        nxt_s.desc_addr = entry_addr(rx_base, s_ff.rx_idx);
                        nxt_s.st = ST_RX_RD0;
                    end
                end else if (stat_req) begin
                    nxt_s.stat_words = stat_words;
                    nxt_s.wcnt = 3'h0;
                    nxt_s.st = ST_STAT_WR;
                end else if (s_ff.err_pend != 6'h00) begin
                    for (int i = `HDRM_ERR_CNTS - 1; i >= 0; i--) begin
                        if (s_ff.err_pend[i]) nxt_s.cnt_sel = 3'(i);
                    end
                    nxt_s.st = ST_CNT_RD;
                end
            end
            ST_CNT_RD: begin
                if (mem_ack) begin
                    nxt_s.rdw = mem_rdata + 16'h0001;
                    nxt_s.st = ST_CNT_WR;
                end
            end
            ST_CNT_WR: begin
                if (mem_ack) begin
                    nxt_s.err_pend[s_ff.cnt_sel] = 1'b0;
                    nxt_s.st = ST_IDLE;
                end
            end
            ST_RX_RD0: begin
                if (mem_ack) begin
                    nxt_s.rd0 = mem_rdata;
                    if (!mem_rdata[`HDRM_OWN_BIT]) begin
                        nxt_s.rx_nodesc = 1'b1;
                        nxt_s.st = ST_IDLE;
                    end else begin
                        nxt_s.st = ST_RX_RD2;
                    end
                end
            end
            ST_RX_RD2: begin
                if (mem_ack) begin
                    nxt_s.rdw = (s_ff.rx_last || !s_ff.desc_ring) ? 16'(-s_ff.rx_count) : mem_rdata;
                    nxt_s.st = ST_RX_WR3;
                end
            end
            ST_RX_WR3: begin
                if (mem_ack) nxt_s.st = ST_RX_WR0;
            end
            ST_RX_WR0: begin
                if (mem_ack) begin
                    nxt_s.st = ST_IDLE;
                    if (s_ff.desc_ring && s_ff.rx_good) begin
                        nxt_idx = s_ff.rx_idx + 7'h01;
                        nxt_s.rx_idx = nxt_idx & ring_mask(s_ff.rx_ptr[`HDRM_SIZE_MSB:`HDRM_SIZE_LSB]);
                        nxt_s.in_chain = !s_ff.rx_last;
                    end else if (s_ff.desc_ring) begin
                        nxt_s.in_chain = 1'b0;
                    end
                end
            end
            ST_STAT_WR: begin
                if (mem_ack) begin
                    nxt_s.wcnt = s_ff.wcnt + 3'h1;
                    if (s_ff.wcnt == `HDRM_STAT_WORDS - 3'h1) nxt_s.st = ST_IDLE;
                end
            end
            default: begin
                nxt_s.st = ST_IDLE;
            end
        endcase

        // new events kept even in the cycle their pending bit clears; a repeat while its bit is still pending merges into it
        nxt_s.err_pend = nxt_s.err_pend | err_event;

        // memory request for the state being entered, held until acknowledged
        nxt_s.mem_req = nxt_s.st != ST_IDLE;
        nxt_s.mem_we = 1'b0;
        nxt_s.mem_addr = 24'h000000;
        nxt_s.mem_wdata = 16'h0000;
        case (nxt_s.st)
            ST_CNT_RD, ST_CNT_WR: begin
                nxt_s.mem_addr = s_ff.init_base + `HDRM_ERR_CNT_OFS + {20'h00000, nxt_s.cnt_sel, 1'b0};
                nxt_s.mem_we = nxt_s.st == ST_CNT_WR;
                nxt_s.mem_wdata = nxt_s.rdw;
            end
            ST_RX_RD0: begin
                nxt_s.mem_addr = nxt_s.desc_addr;
            end
            ST_RX_RD2: begin
                nxt_s.mem_addr = nxt_s.desc_addr + `HDRM_DESC_W2_OFS;
            end
            ST_RX_WR3: begin
                nxt_s.mem_addr = nxt_s.desc_addr + `HDRM_DESC_W3_OFS;
                nxt_s.mem_we = 1'b1;
                nxt_s.mem_wdata = nxt_s.rdw;
            end
            ST_RX_WR0: begin
                nxt_s.mem_addr = nxt_s.desc_addr;
                nxt_s.mem_we = 1'b1;
                nxt_s.mem_wdata = nxt_s.rd0;
                nxt_s.mem_wdata[`HDRM_OWN_BIT] = !nxt_s.rx_good;
                nxt_s.mem_wdata[`HDRM_SOC_BIT] = !nxt_s.desc_ring || !nxt_s.in_chain;
                nxt_s.mem_wdata[`HDRM_EOC_BIT] = !nxt_s.desc_ring || nxt_s.rx_last;
                nxt_s.mem_wdata[`HDRM_UI_BIT] = nxt_s.rx_kind == KIND_UI;
                nxt_s.mem_wdata[`HDRM_FRMR_BIT] = nxt_s.rx_kind == KIND_FRMR;
                nxt_s.mem_wdata[`HDRM_MATCH_BIT] = nxt_s.rx_match;
                nxt_s.mem_wdata[`HDRM_PF_BIT] = (nxt_s.rx_kind == KIND_UI || nxt_s.rx_kind == KIND_XID ||
                                                 nxt_s.rx_kind == KIND_TEST) && nxt_s.rx_pf;
            end
            ST_STAT_WR: begin
                nxt_s.mem_addr = {s_ff.sb_hi, s_ff.sb_lo} + {20'h00000, nxt_s.wcnt, 1'b0};
                nxt_s.mem_we = 1'b1;
                nxt_s.mem_wdata = nxt_s.stat_words[{nxt_s.wcnt, 4'h0} +: 16];
            end
            default: begin
                nxt_s.mem_req = 1'b0;
            end
        endcase
        nxt_s.cmd_ready = nxt_s.st == ST_IDLE;
    end

    // --------
    // state register
    // --------

    // all state in one register, cleared by reset except cmd_ready set to one and seq_mask set to 7'h07
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.st <= ST_IDLE;
            s_ff.cmd_ready <= 1'b1;
            s_ff.seq_mask <= 7'h07;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign prdata = s_ff.prdata;
    assign pready = s_ff.pready;
    assign pslverr = s_ff.pslverr;
    assign mem_req = s_ff.mem_req;
    assign mem_we = s_ff.mem_we;
    assign mem_addr = s_ff.mem_addr;
    assign mem_wdata = s_ff.mem_wdata;
    assign cmd_ready = s_ff.cmd_ready;
    assign tx_window_open = s_ff.tx_window_open;
    assign tx_idx = s_ff.tx_idx;
    assign two_octet_ctrl = s_ff.two_octet_ctrl;
    assign seq_mask = s_ff.seq_mask;
    assign prim_valid = s_ff.prim_valid;
    assign prim_code = s_ff.prim_code;

endmodule // hdrm_ring_mgr

`default_nettype wire

/* File: hdrm_regs.svh */
// register offsets, field positions, write masks and fixed counts of the descriptor ring manager
`ifndef HDRM_REGS_SVH
`define HDRM_REGS_SVH

// --------
// apb register byte offsets
// --------
`define HDRM_RX_RING_PTR 8'h00
`define HDRM_RX_RING_LO 8'h04
`define HDRM_TX_RING_PTR 8'h08
`define HDRM_TX_RING_LO 8'h0C
`define HDRM_STAT_BUF_PTR 8'h10
`define HDRM_STAT_BUF_LO 8'h14
`define HDRM_INIT_BASE 8'h18
`define HDRM_XID_DESC 8'h1C
`define HDRM_TEST_DESC 8'h20
`define HDRM_CTRL 8'h24
`define HDRM_STATUS 8'h28

// --------
// ring pointer word fields
// --------
`define HDRM_SIZE_MSB 14
`define HDRM_SIZE_LSB 12
`define HDRM_RB_EN_BIT 11
`define HDRM_WIN_MSB 10
`define HDRM_WIN_LSB 8
`define HDRM_HI_MSB 7
`define HDRM_RX_PTR_MASK 16'h78FF
`define HDRM_TX_PTR_MASK 16'h77FF

// --------
// receive descriptor word 0 fields
// --------
`define HDRM_OWN_BIT 15
`define HDRM_SEC_BIT 14
`define HDRM_SOC_BIT 13
`define HDRM_EOC_BIT 12
`define HDRM_UI_BIT 11
`define HDRM_FRMR_BIT 10
`define HDRM_MATCH_BIT 9
`define HDRM_PF_BIT 8

// --------
// status register fields
// --------
`define HDRM_ST_NODESC_BIT 25
`define HDRM_ST_CFGERR_BIT 26

// --------
// memory layout and fixed codes
// --------
`define HDRM_ERR_CNT_OFS 24'h00002C
`define HDRM_DESC_W2_OFS 24'h000004
`define HDRM_DESC_W3_OFS 24'h000006
`define HDRM_STAT_WORDS 3'h7
`define HDRM_ERR_CNTS 6
`define HDRM_PRIM_REMOTE_BUSY 4'h5
`define HDRM_WIN_MAX 7'h7F

`endif

/* File: hdrm_pkg.sv */
// types shared by the descriptor ring manager
`default_nettype none
package hdrm_pkg;

    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_CNT_RD, ST_CNT_WR, ST_RX_RD0, ST_RX_RD2, ST_RX_WR3, ST_RX_WR0, ST_STAT_WR
    } hdrm_seq_t;

    // kind of the received frame reported by the protocol engine
    typedef enum logic [2:0] {
        KIND_I, KIND_UI, KIND_FRMR, KIND_XID, KIND_TEST, KIND_OTHER
    } hdrm_kind_t;

    // whole state of the ring manager
    typedef struct packed {
        hdrm_seq_t st;
        logic [15:0] rx_ptr;
        logic [15:0] rx_lo;
        logic [15:0] tx_ptr;
        logic [15:0] tx_lo;
        logic [7:0] sb_hi;
        logic [15:0] sb_lo;
        logic [23:0] init_base;
        logic [23:0] xid_desc;
        logic [23:0] test_desc;
        logic ext_en;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [6:0] rx_idx;
        logic [6:0] tx_idx;
        logic [6:0] vs;
        logic [6:0] va;
        logic in_chain;
        logic rx_nodesc;
        logic cfg_err;
        logic [5:0] err_pend;
        logic [2:0] cnt_sel;
        logic [2:0] wcnt;
        logic [23:0] desc_addr;
        logic desc_ring;
        logic [15:0] rd0;
        logic [15:0] rdw;
        logic rx_last;
        logic rx_good;
        hdrm_kind_t rx_kind;
        logic rx_pf;
        logic rx_match;
        logic [15:0] rx_count;
        logic [111:0] stat_words;
        logic rb_prev;
        logic prim_valid;
        logic [3:0] prim_code;
        logic mem_req;
        logic mem_we;
        logic [23:0] mem_addr;
        logic [15:0] mem_wdata;
        logic cmd_ready;
        logic tx_window_open;
        logic two_octet_ctrl;
        logic [6:0] seq_mask;
    } hdrm_state_t;

endpackage
`default_nettype wire

/* File: hdrm_mem_model.sv */
// host memory model that answers the ring manager's word port
`timescale 1ns/1ps
`default_nettype none
module hdrm_mem_model (
    // clock, reset and answer latency
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] lat,
    // word port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] mem [0:255]; // four words per descriptor
    logic [3:0] dly;
    // ack after lat waiting cycles, write lands on the ack edge only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            dly <= 4'h0;
        end else begin
            mem_ack <= mem_req && !mem_ack && dly >= lat;
            dly <= (mem_req && !mem_ack && dly < lat) ? dly + 4'h1 : 4'h0;
            if (mem_req && mem_ack && mem_we) mem[mem_addr[8:1]] <= mem_wdata;
        end
    end
    // outside the ack cycle the data lines show the inverse, never a stale match
    assign mem_rdata = mem_ack ? mem[mem_addr[8:1]] : ~mem[mem_addr[8:1]];
endmodule // hdrm_mem_model
`default_nettype wire

/* File: hdrm_ring_mgr_chk.sv */
// concurrent checks on the ring manager ports
`timescale 1ns/1ps
`default_nettype none
module hdrm_ring_mgr_chk (
    // clock and reset
    input wire logic pclk, presetn,
    // apb answer
    input wire logic psel, penable, pready, pslverr,
    // memory port
    input wire logic mem_req, mem_we, mem_ack,
    input wire logic [23:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    // commands, control and primitives
    input wire logic rx_done, cmd_ready, remote_busy, prim_valid, two_octet_ctrl,
    input wire logic [3:0] prim_code,
    input wire logic [6:0] seq_mask
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a taken buffer starts with a descriptor read
    sequence s_rx_take; rx_done && cmd_ready; endsequence
    sequence s_desc_read; !cmd_ready && mem_req && !mem_we; endsequence
    a_rx_start_read: assert property (s_rx_take |=> s_desc_read) else $error("rx buffer not started");
    a_apb_answer: assert property ($rose(penable) && psel |=> pready ##1 !pready) else $error("apb answer late");
    a_err_ready: assert property (pslverr |-> pready) else $error("slverr without ready");
    a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
        && $stable(mem_wdata)) else $error("memory request changed");
    a_word_addr: assert property (mem_req |-> !mem_addr[0]) else $error("odd word address");
    a_prim_code: assert property (prim_valid |-> prim_code == 4'h5) else $error("bad primitive code");
    a_prim_cause: assert property (prim_valid |-> $past(remote_busy) != $past(remote_busy, 2))
        else $error("primitive without busy change");
    a_seq_mask: assert property (seq_mask == (two_octet_ctrl ? 7'h7F : 7'h07)) else $error("bad modulus");
endmodule // hdrm_ring_mgr_chk
bind hdrm_ring_mgr hdrm_ring_mgr_chk i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .mem_req,
    .mem_we, .mem_ack, .mem_addr, .mem_wdata, .rx_done, .cmd_ready, .remote_busy, .prim_valid,
    .two_octet_ctrl, .prim_code, .seq_mask);
`default_nettype wire

/* File: tb_hdlc_descriptor_ring_manager.sv */
// self-checking bench of the descriptor ring manager
`timescale 1ns/1ps
`include "hdrm_regs.svh"
`default_nettype none
module tb_hdlc_descriptor_ring_manager;
    import hdrm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, mem_req, mem_we, mem_ack;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [23:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata, rx_count = 0;
    logic rx_done = 0, rx_last = 0, rx_good = 0, rx_pf = 0, rx_match = 0, stat_req = 0, tx_sent = 0, tx_ack = 0;
    logic remote_busy = 0, cmd_ready, tx_window_open, two_octet_ctrl, prim_valid;
    hdrm_kind_t rx_kind = KIND_I;
    logic [111:0] stat_words = 0;
    logic [5:0] err_event = 0;
    logic [6:0] tx_nr = 0, tx_idx, seq_mask;
    logic [3:0] prim_code, lat = 0;
    int mismatches = 0, num_checks = 0, prims = 0;
    hdrm_ring_mgr i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .rx_done, .rx_last, .rx_good, .rx_kind,
        .rx_pf, .rx_match, .rx_count, .cmd_ready, .stat_req, .stat_words, .err_event, .tx_sent, .tx_ack, .tx_nr,
        .tx_window_open, .tx_idx, .two_octet_ctrl, .seq_mask, .remote_busy, .prim_valid, .prim_code);
    hdrm_mem_model i_mem (.pclk, .presetn, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
    // clock and primitive pulse count
    always #5 pclk = ~pclk;
    always @(posedge pclk) if (prim_valid === 1'b1) prims++;
    // compare, report and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1, a, d, q, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(0, a, 0, q, e);
        chk(q, x);
    endtask
    // host memory access and polled comparison
    task automatic mset(input logic [23:0] a, input logic [15:0] v);
        i_mem.mem[a[8:1]] = v;
    endtask
    task automatic mchk(input logic [23:0] a, input logic [15:0] x);
        for (int n = 0; n < 100 && i_mem.mem[a[8:1]] !== x; n++) @(posedge pclk);
        chk({16'h0, i_mem.mem[a[8:1]]}, {16'h0, x});
    endtask
    // one finished receive buffer, waits for the sequencer to go idle again
    task automatic rx(input logic l, g, input hdrm_kind_t k, input logic p, m, input logic [15:0] c);
        while (cmd_ready !== 1'b1) @(posedge pclk);
        rx_done <= 1;
        {rx_last, rx_good, rx_pf, rx_match, rx_count} <= {l, g, p, m, c};
        rx_kind <= k;
        @(posedge pclk) rx_done <= 0;
        do @(posedge pclk); while (cmd_ready !== 1'b1);
    endtask
    task automatic pulse_tx(input logic ack);
        tx_sent <= !ack;
        tx_ack <= ack;
        @(posedge pclk) {tx_sent, tx_ack} <= 2'b00;
        repeat (2) @(posedge pclk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        $display("ERROR %0t watchdog expired", $time);
        close_out;
    end
    // main sequence
    initial begin : main
        logic [31:0] q;
        logic e;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        wr(`HDRM_RX_RING_PTR, 32'hFFFF_FFFF);
        rdc(`HDRM_RX_RING_PTR, {16'h0, `HDRM_RX_PTR_MASK});
        apb(0, 8'h2C, 0, q, e);
        chk({31'h0, e}, 32'h1);
        wr(`HDRM_RX_RING_PTR, 32'h1000);
        wr(`HDRM_RX_RING_LO, 32'h40);
        wr(`HDRM_INIT_BASE, 32'h100);
        mset(24'h40, 16'hC000);
        mset(24'h42, 16'h1234);
        mset(24'h44, 16'hFFF0);
        mset(24'h48, 16'h8000);
        mset(24'h4C, 16'hFFF0);
        rx(0, 1, KIND_I, 1, 1, 16'h000A);
        mchk(24'h46, 16'hFFF0);
        mchk(24'h40, 16'h6200);
        rx(1, 1, KIND_UI, 1, 0, 16'h0006);
        mchk(24'h4E, 16'hFFFA);
        mchk(24'h48, 16'h1900);
        rx(1, 1, KIND_I, 0, 0, 16'h0004);
        rdc(`HDRM_STATUS, 32'h0200_0000);
        wr(`HDRM_STATUS, 32'h0200_0000);
        mset(24'h40, 16'h8000);
        lat <= 3;
        rx(1, 0, KIND_FRMR, 1, 0, 16'h0004);
        mchk(24'h40, 16'hB400);
        mchk(24'h42, 16'h1234);
        mchk(24'h44, 16'hFFF0);
        wr(`HDRM_XID_DESC, 32'h60);
        mset(24'h60, 16'h8000);
        mset(24'h64, 16'hFFF8);
        rx(0, 1, KIND_XID, 1, 1, 16'h0008);
        mchk(24'h60, 16'h3300);
        mset(24'h12C, 16'h0005);
        mset(24'h136, 16'hFFFF);
        err_event <= 6'h21;
        @(posedge pclk) err_event <= 0;
        mchk(24'h12C, 16'h0006);
        mchk(24'h136, 16'h0000);
        wr(`HDRM_STAT_BUF_LO, 32'h180);
        mset(24'h18A, 16'hFFFF);
        stat_words <= {16'h6666, 80'h0, 16'h1111};
        while (cmd_ready !== 1'b1) @(posedge pclk);
        stat_req <= 1;
        @(posedge pclk) stat_req <= 0;
        mchk(24'h180, 16'h1111);
        mchk(24'h18A, 16'h0000);
        mchk(24'h18C, 16'h6666);
        wr(`HDRM_RX_RING_PTR, 32'h1800);
        remote_busy <= 1;
        repeat (3) @(posedge pclk);
        remote_busy <= 0;
        repeat (3) @(posedge pclk);
        wr(`HDRM_RX_RING_PTR, 32'h1000);
        remote_busy <= 1;
        repeat (3) @(posedge pclk);
        chk(prims, 2);
        wr(`HDRM_TX_RING_PTR, 32'h1200);
        repeat (2) pulse_tx(0);
        chk({24'h0, tx_idx, tx_window_open}, 32'h0);
        tx_nr <= 7'h02;
        pulse_tx(1);
        chk({31'h0, tx_window_open}, 32'h1);
        wr(`HDRM_CTRL, 32'h1);
        wr(`HDRM_TX_RING_PTR, 32'h1000);
        chk({24'h0, seq_mask, two_octet_ctrl}, {24'h0, 7'h7F, 1'b1});
        pulse_tx(0);
        chk({31'h0, tx_window_open}, 32'h0);
        close_out;
    end
endmodule // tb_hdlc_descriptor_ring_manager
`default_nettype wire
